// ### hpad_dev_model.sv
// Purpose: Behavioural USB devices on the seven downstream ports.
// Assumes: The bench picks per port: no device, full or low speed.
// Notes:   Hub drive wins over device bias while ds_oe is high.
`timescale 1ns/1ns
module hpad_dev_model (
  input  wire logic [6:0] plug,
  input  wire logic [6:0] slow,
  input  wire logic [6:0] oe,
  input  wire logic [6:0] dp_out,
  input  wire logic [6:0] dm_out,
  output logic      [6:0] dp,
  output logic      [6:0] dm
);
  // Empty port falls to SE0 through the pull-downs
  assign dp = (oe & dp_out) | (~oe & plug & ~slow);
  assign dm = (oe & dm_out) | (~oe & plug & slow);
endmodule

// ### hpad_hub.sv
// Purpose: Downstream port attach detection, port registers, hub
//          interrupt and end of packet at EOF1 for a hub repeater.
// Assumes: All inputs synchronous to clock; one clock domain.
// Notes:   A frame timer elsewhere pulses sof_tick at each frame start.
//
// What this block does
// R1: D+ low with D- high marks a low-speed attach and sets the flag.
// R2: D+ high with D- low marks a full-speed attach and sets the flag.
// R3: Setting an attach flag raises the hub interrupt.
// R4: Attach is recorded only after non-SE0 lasts beyond 2.5 us.
// R5: Detach is recognised after SE0 lasts between 2.0 and 2.5 us.
// R6: Detach clears the port's flag and raises the hub interrupt.
// R7: Both lines low means no device attached.
// R8: Attach register bit x-1 shows port x; one is attached.
// R9: Attach register clears on reset or bus reset, then tracks ports.
// R10: Top bit of the attach register always reads zero.
// R11: Speed register bit x-1 is port x; one means low speed.
// R12: Speed register clears on reset or bus reset; top bit reads zero.
// R13: Firmware writes the port speed when it resets that port.
// R14: An end of packet is driven downstream at EOF1 of each frame.
// R15: Upstream SE0 of 12 to 16 us is taken as a bus reset.
// R16: Filters count clock cycles and restart on any line change.
// R17: One shared hub interrupt covers every attach or detach change.
`timescale 1ns/1ns
module hpad_hub
  import hpad_pkg::*;
#(
  parameter int NUM_PORTS   = 7,
  parameter int EOF1_CYCLES = 124000
)
(
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire logic                 clk_en,
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic [REG_W-1:0]     reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [REG_W-1:0]     reg_rdata,
  input  wire logic [NUM_PORTS-1:0] ds_dp_in,
  input  wire logic [NUM_PORTS-1:0] ds_dm_in,
  output logic      [NUM_PORTS-1:0] ds_dp_out,
  output logic      [NUM_PORTS-1:0] ds_dm_out,
  output logic      [NUM_PORTS-1:0] ds_oe,
  input  wire logic                 up_dp_in,
  input  wire logic                 up_dm_in,
  input  wire logic                 sof_tick,
  output logic                      bus_reset_active,
  output logic                      hub_irq
);

  localparam int ST_W = NUM_PORTS + 1;

  logic [NUM_PORTS-1:0] port_attach_flags;
  logic [NUM_PORTS-1:0] port_low_speed_flags;
  logic [ST_W-1:0]      int_status;
  logic [ST_W-1:0]      int_mask;
  logic [NUM_PORTS-1:0] attach_evt;
  logic [NUM_PORTS-1:0] detach_evt;
  logic [NUM_PORTS-1:0] port_seen;
  logic [UP_W-1:0]      up_se0_cnt;
  logic [FRAME_W-1:0]   frame_cnt;
  logic [EOP_W-1:0]     eop_cnt;
  hpad_eop_t            eop_state;
  hpad_eop_t            next_eop_state;

  // Per-port line filters
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      hpad_port_filter u_filter (
        .clock      (clock),
        .nrst       (nrst),
        .clk_en     (clk_en),
        .clear      (bus_reset_active),
        .line_dp    (ds_dp_in[gi]),
        .line_dm    (ds_dm_in[gi]),
        .attached   (port_seen[gi]),
        .attach_evt (attach_evt[gi]),
        .detach_evt (detach_evt[gi])
      );
    end
  endgenerate

  // Upstream bus reset detection
  wire up_se0       = ~up_dp_in & ~up_dm_in;
  wire up_cnt_done  = up_se0_cnt == UP_RESET_CNT;
  wire up_reset_hit = up_se0 & (up_se0_cnt == UP_RESET_CNT - 1'b1); // R15
  // Interrupt is raised when SE0 goes away, not when it is first seen
  wire bus_reset_end = bus_reset_active & ~up_se0;

  wire [UP_W-1:0] next_up_se0_cnt =
    ~up_se0 ? '0 : up_cnt_done ? up_se0_cnt : up_se0_cnt + 1'b1;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      up_se0_cnt       <= '0;
      bus_reset_active <= 1'b0;
    end else if (clk_en) begin
      up_se0_cnt       <= next_up_se0_cnt;
      bus_reset_active <= up_se0 & (bus_reset_active | up_reset_hit); // R15
    end
  end

  // Register decode
  wire wr_attach = reg_wr & (reg_addr == REG_ATTACH);
  wire wr_speed  = reg_wr & (reg_addr == REG_LOW_SPEED);
  wire wr_status = reg_wr & (reg_addr == REG_INT_STATUS);
  wire wr_mask   = reg_wr & (reg_addr == REG_INT_MASK);

  wire [NUM_PORTS-1:0] wdata_ports = reg_wdata[NUM_PORTS-1:0];
  wire [ST_W-1:0]      wdata_st    = reg_wdata[ST_W-1:0];

  // Line events override a firmware write in the same cycle
  wire [NUM_PORTS-1:0] attach_base =
    wr_attach ? wdata_ports : port_attach_flags;
  wire [NUM_PORTS-1:0] next_attach =
    bus_reset_active ? '0 : // R9
    (attach_base | attach_evt) & ~detach_evt; // R1 R2 R6 R8

  wire [NUM_PORTS-1:0] next_low_speed =
    bus_reset_active ? '0 : // R12
    wr_speed ? wdata_ports : port_low_speed_flags; // R11

  // Status: port changes low, bus reset end on top; set beats clear
  wire [NUM_PORTS-1:0] port_change = attach_evt | detach_evt; // R17
  wire [ST_W-1:0] st_events = {bus_reset_end, port_change}; // R3 R6
  wire [ST_W-1:0] st_clear  = wr_status ? wdata_st : '0;
  wire [ST_W-1:0] next_status = (int_status & ~st_clear) | st_events;
  wire [ST_W-1:0] next_mask   = wr_mask ? wdata_st : int_mask;
  wire            next_irq    = |(int_status & int_mask); // R17

  always_ff @(posedge clock) begin
    if (!nrst) begin
      port_attach_flags    <= '0;
      port_low_speed_flags <= '0;
      int_status           <= '0;
      int_mask             <= '0;
      hub_irq              <= 1'b0;
    end else if (clk_en) begin
      port_attach_flags    <= next_attach;
      port_low_speed_flags <= next_low_speed;
      int_status           <= next_status;
      int_mask             <= next_mask;
      hub_irq              <= next_irq;
    end
  end

  // Read path: narrow registers zero-extend, so the top bit reads zero
  wire [REG_W-1:0] rd_word =
    (reg_addr == REG_ATTACH)     ? REG_W'(port_attach_flags) : // R10
    (reg_addr == REG_LOW_SPEED)  ? REG_W'(port_low_speed_flags) : // R12
    (reg_addr == REG_INT_STATUS) ? REG_W'(int_status) :
    (reg_addr == REG_INT_MASK)   ? REG_W'(int_mask) :
                                   REG_RESET;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      reg_rdata <= REG_RESET;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_word : REG_RESET;
    end
  end

  // Frame timer and end of packet at EOF1
  wire eof1_hit = frame_cnt == FRAME_W'(EOF1_CYCLES); // R14

  always_comb begin
    next_eop_state = eop_state;
    case (eop_state)
      EOP_IDLE: begin
        if (sof_tick) begin
          next_eop_state = EOP_COUNT;
        end
      end
      EOP_COUNT: begin
        if (eof1_hit) begin
          next_eop_state = EOP_SE0; // R14
        end
      end
      EOP_SE0: begin
        if (eop_cnt == EOP_SE0_LAST) begin
          next_eop_state = EOP_J;
        end
      end
      EOP_J: begin
        if (eop_cnt == EOP_J_LAST) begin
          next_eop_state = EOP_IDLE;
        end
      end
      default: begin
        next_eop_state = EOP_IDLE;
      end
    endcase
    if (bus_reset_active) begin
      next_eop_state = EOP_IDLE;
    end
  end

  // A fresh frame start while counting restarts the frame
  wire frame_restart = sof_tick & (eop_state != EOP_SE0) &
                       (eop_state != EOP_J);
  wire [FRAME_W-1:0] next_frame_cnt =
    (frame_restart | (eop_state != EOP_COUNT)) ? '0 : frame_cnt + 1'b1;
  wire [EOP_W-1:0] next_eop_cnt =
    (next_eop_state != eop_state) ? '0 : eop_cnt + 1'b1;

  // Idle J differs by speed: D+ high full speed, D- high low speed
  wire drive_on = (next_eop_state == EOP_SE0) | (next_eop_state == EOP_J);
  wire drive_j  = next_eop_state == EOP_J;
  wire [NUM_PORTS-1:0] next_dp = drive_j ? ~port_low_speed_flags : '0;
  wire [NUM_PORTS-1:0] next_dm = drive_j ? port_low_speed_flags : '0;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      eop_state <= EOP_IDLE;
      frame_cnt <= '0;
      eop_cnt   <= '0;
      ds_oe     <= '0;
      ds_dp_out <= '0;
      ds_dm_out <= '0;
    end else if (clk_en) begin
      eop_state <= next_eop_state;
      frame_cnt <= next_frame_cnt;
      eop_cnt   <= next_eop_cnt;
      ds_oe     <= {NUM_PORTS{drive_on}};
      ds_dp_out <= next_dp;
      ds_dm_out <= next_dm;
    end
  end

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence eop_se0_seq;
    (ds_oe == '1 && ds_dp_out == '0 && ds_dm_out == '0) [*8];
  endsequence

  sequence eop_j_seq;
    ds_oe == '1 && ds_dp_out == ~port_low_speed_flags &&
    ds_dm_out == port_low_speed_flags;
  endsequence

  chk_flag_set: // R8
  assert property (clk_en && attach_evt != '0 && !bus_reset_active |=>
                   (port_attach_flags & $past(attach_evt)) ==
                   $past(attach_evt))
    else $error("attach event did not set its port flag");

  chk_flag_clear: // R6
  assert property (clk_en && detach_evt != '0 && !bus_reset_active |=>
                   (port_attach_flags & $past(detach_evt)) == '0)
    else $error("detach event did not clear its port flag");

  chk_change_irq: // R3 R17
  assert property (clk_en && (port_change & int_mask[NUM_PORTS-1:0]) != '0
                   ##1 clk_en |=> hub_irq)
    else $error("unmasked port change did not raise the interrupt");

  chk_bus_clear: // R9
  assert property (clk_en && bus_reset_active |=>
                   port_attach_flags == '0 && port_low_speed_flags == '0)
    else $error("bus reset left port registers set");

  chk_reset_detect: // R15
  assert property (clk_en && up_reset_hit |=> bus_reset_active)
    else $error("long upstream SE0 was not taken as bus reset");

  chk_speed_write: // R11
  assert property (clk_en && wr_speed && !bus_reset_active |=>
                   port_low_speed_flags == $past(wdata_ports))
    else $error("speed register did not take the written value");

  chk_read_reserved: // R10 R12
  assert property (clk_en && reg_rd &&
                   (reg_addr == REG_ATTACH || reg_addr == REG_LOW_SPEED)
                   |=> reg_rdata[RESERVED_BIT] == 1'b0)
    else $error("reserved top bit read as one");

  chk_eop_at_eof1: // R14
  assert property (clk_en && eop_state == EOP_COUNT && eof1_hit &&
                   !bus_reset_active |=> eop_se0_seq)
    else $error("no SE0 driven downstream at EOF1");

  chk_eop_tail: // R14
  assert property (clk_en && eop_state == EOP_SE0 &&
                   next_eop_state == EOP_J |=> eop_j_seq)
    else $error("end of packet did not finish with idle J");

  chk_event_seen: // R1 R2 R6
  assert property ((port_seen & port_change) == attach_evt)
    else $error("port event disagrees with the filtered line state");

endmodule

// ### hpad_pkg.sv
// Purpose: Shared constants and types of the hub port attach logic.
// Assumes: Clock of 125 MHz, registers eight bits wide.
// Notes:   Counts are derived from times, never typed by hand.
package hpad_pkg;

  // Clock
  localparam int CLK_PERIOD_PS = 8000;

  // Line state filter timing on downstream ports
  localparam int ATTACH_MIN_NS = 2500;
  localparam int DETACH_MIN_NS = 2000;
  localparam int DETACH_MAX_NS = 2500;
  localparam int ATTACH_CYC =
    (ATTACH_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DETACH_CYC =
    (DETACH_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DETACH_MAX_CYC = (DETACH_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int FILT_W = 9;
  localparam logic [FILT_W-1:0] ATTACH_CNT = FILT_W'(ATTACH_CYC);
  localparam logic [FILT_W-1:0] DETACH_CNT = FILT_W'(DETACH_CYC);
  localparam logic [FILT_W-1:0] DETACH_MAX_CNT = FILT_W'(DETACH_MAX_CYC);
  localparam logic [FILT_W-1:0] FILT_MAX = {FILT_W{1'b1}};

  // Upstream bus reset: least SE0 time that is taken as reset
  localparam int UP_RESET_MIN_US = 12;
  localparam int UP_RESET_CYC =
    (UP_RESET_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int UP_W = 11;
  localparam logic [UP_W-1:0] UP_RESET_CNT = UP_W'(UP_RESET_CYC);

  // End of packet driven at EOF1: two bit times SE0, one bit time J
  localparam int FS_BIT_PS = 83333;
  localparam int EOP_SE0_CYC =
    (2 * FS_BIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EOP_J_CYC = (FS_BIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EOP_W = 5;
  localparam logic [EOP_W-1:0] EOP_SE0_LAST = EOP_W'(EOP_SE0_CYC - 1);
  localparam logic [EOP_W-1:0] EOP_J_LAST = EOP_W'(EOP_J_CYC - 1);
  localparam int FRAME_W = 17;

  // Register map
  localparam int REG_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_ATTACH = 8'h48;
  localparam logic [ADDR_W-1:0] REG_LOW_SPEED = 8'h4A;
  localparam logic [ADDR_W-1:0] REG_INT_STATUS = 8'h60;
  localparam logic [ADDR_W-1:0] REG_INT_MASK = 8'h61;
  localparam int RESERVED_BIT = 7;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  typedef enum logic [1:0] {
    EOP_IDLE  = 2'b00,
    EOP_COUNT = 2'b01,
    EOP_SE0   = 2'b10,
    EOP_J     = 2'b11
  } hpad_eop_t;

endpackage

// ### hpad_port_filter.sv
// Purpose: Attach and detach filter for one downstream line pair.
// Assumes: Line inputs synchronous to clock.
// Notes:   Events are one-cycle pulses from flops.
`timescale 1ns/1ns
module hpad_port_filter
  import hpad_pkg::*;
(
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic clk_en,
  input  wire logic clear,
  input  wire logic line_dp,
  input  wire logic line_dm,
  output logic      attached,
  output logic      attach_evt,
  output logic      detach_evt
);

  logic [1:0]        line_prev;
  logic [FILT_W-1:0] run_cnt;
  logic [FILT_W-1:0] next_run_cnt;

  wire line_se0   = ~line_dp & ~line_dm; // R7
  wire line_jk    = line_dp ^ line_dm; // R1 R2
  wire line_moved = {line_dp, line_dm} != line_prev;
  wire cnt_sat    = run_cnt == FILT_MAX;

  // Any change of the sampled pair restarts the run
  assign next_run_cnt = line_moved ? '0 : // R16
                        cnt_sat ? run_cnt : run_cnt + 1'b1;

  wire hit_attach = ~attached & line_jk & ~line_moved &
                    (run_cnt >= ATTACH_CNT); // R4
  wire hit_detach = attached & line_se0 & ~line_moved &
                    (run_cnt >= DETACH_CNT); // R5

  always_ff @(posedge clock) begin
    if (!nrst) begin
      line_prev  <= 2'h0;
      run_cnt    <= '0;
      attached   <= 1'b0;
      attach_evt <= 1'b0;
      detach_evt <= 1'b0;
    end else if (clk_en) begin
      line_prev  <= {line_dp, line_dm};
      run_cnt    <= clear ? '0 : next_run_cnt;
      attached   <= clear ? 1'b0 : attached ? ~hit_detach : hit_attach;
      attach_evt <= ~clear & hit_attach;
      detach_evt <= ~clear & hit_detach;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  chk_attach_time: // R4
  assert property ($rose(attached) |-> $past(run_cnt) >= ATTACH_CNT)
    else $error("attach recorded before the line run was long enough");

  chk_attach_low: // R1
  assert property ($rose(attached) && $past(line_dm) |-> !$past(line_dp))
    else $error("attach taken without a low-speed idle pair");

  chk_attach_full: // R2
  assert property ($rose(attached) && $past(line_dp) |-> !$past(line_dm))
    else $error("attach taken without a full-speed idle pair");

  chk_detach_window: // R5
  assert property ($fell(attached) && !$past(clear) |->
                   $past(line_se0) && $past(run_cnt) >= DETACH_CNT &&
                   $past(run_cnt) <= DETACH_MAX_CNT)
    else $error("detach outside the SE0 time window");

  chk_filter_restart: // R16
  assert property (clk_en && !clear && line_moved |=> run_cnt == '0)
    else $error("filter run did not restart on a line change");

  chk_idle_state: // R7
  assert property (clk_en && !attached && line_se0 |=> !attached)
    else $error("pulled-down pair was taken as an attach");

endmodule

// ### tb_hpad_hub.sv
// Purpose: Self-checking bench for the hub port attach logic.
// Assumes: Frame length shortened to 200 cycles.
// Notes:   Fixed waits follow the filter counts in the package.
`timescale 1ns/1ns
module tb_hpad_hub;
  import hpad_pkg::*;
  logic       clock, nrst, reg_wr, reg_rd, up_dp, up_dm, sof_tick;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [6:0] plug, slow, dp, dm, dp_out, dm_out, oe, m, s;
  logic       bra, hub_irq, clk_en;
  int         err_total, n_checks;
  integer     seed;

  hpad_hub #(.NUM_PORTS(7), .EOF1_CYCLES(200)) hpad_hub_inst (
    .clock(clock), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ds_dp_in(dp), .ds_dm_in(dm),
    .ds_dp_out(dp_out), .ds_dm_out(dm_out), .ds_oe(oe),
    .up_dp_in(up_dp), .up_dm_in(up_dm), .sof_tick(sof_tick),
    .bus_reset_active(bra), .hub_irq(hub_irq));

  hpad_dev_model hpad_dev_model_inst (
    .plug(plug), .slow(slow), .oe(oe), .dp_out(dp_out),
    .dm_out(dm_out), .dp(dp), .dm(dm));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Port registers read back with the reserved top bit clear
  function automatic logic [7:0] port_word(input logic [6:0] bits);
    return {1'b0, bits};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    chk(v, exp);
    @(posedge clock);
  endtask

  // Callers wait 1 ns first, so the value copied in has settled
  task automatic see(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
    @(posedge clock);
  endtask

  task automatic eop_test(input logic [6:0] sp);
    int n0, n1;
    n0 = 0;
    n1 = 0;
    sof_tick <= 1'b1;
    @(posedge clock);
    sof_tick <= 1'b0;
    repeat (300) begin
      @(posedge clock);
      #1;
      if (oe === 7'h7F && dp_out === 7'h00 && dm_out === 7'h00)
        n0++;
      if (oe === 7'h7F && dp_out === ~sp && dm_out === sp)
        n1++;
    end
    @(posedge clock);
    chk(8'(n0), 8'(EOP_SE0_CYC));
    chk(8'(n1), 8'(EOP_J_CYC));
  endtask

  initial begin
    #160000;
    err_total++;
    finish_test();
  end

  initial begin
    seed = 34889;
    err_total = 0;
    n_checks = 0;
    nrst = 1'b0;
    clk_en = 1'b1;
    {reg_wr, reg_rd, sof_tick, up_dm} = 4'h0;
    up_dp = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    plug = 7'h00;
    slow = 7'h00;
    cyc(6);
    nrst <= 1'b1;
    @(posedge clock);
    rdc(REG_ATTACH, 8'h00);
    rdc(REG_LOW_SPEED, 8'h00);
    rdc(REG_INT_STATUS, 8'h00);
    rdc(REG_INT_MASK, 8'h00);
    rdc(8'h50, 8'h00);
    #1 see(hub_irq, 1'b0);
    wr(REG_INT_MASK, 8'hFF);
    $display("reset test done");
    for (int r = 0; r < 2; r++) begin
      m = 7'($random(seed)) | 7'h01;
      s = 7'($random(seed));
      slow <= s;
      plug <= m;
      cyc(300);
      rdc(REG_ATTACH, 8'h00);
      // Swap J and K mid-run: the filter must start over
      slow <= ~s;
      cyc(300);
      rdc(REG_ATTACH, 8'h00);
      slow <= s;
      plug <= 7'h00;
      cyc(320);
      rdc(REG_ATTACH, 8'h00);
      rdc(REG_INT_STATUS, 8'h00);
      plug <= m;
      wr(REG_LOW_SPEED, {1'b1, s});
      cyc(320);
      rdc(REG_ATTACH, port_word(m));
      rdc(REG_LOW_SPEED, port_word(s));
      rdc(REG_INT_STATUS, port_word(m));
      #1 see(hub_irq, 1'b1);
      wr(REG_INT_MASK, 8'h00);
      #1 see(hub_irq, 1'b0);
      wr(REG_INT_MASK, 8'hFF);
      #1 see(hub_irq, 1'b1);
      wr(REG_INT_STATUS, 8'hFF);
      #1 see(hub_irq, 1'b0);
      wr(REG_ATTACH, {1'b1, m});
      rdc(REG_ATTACH, port_word(m));
      plug <= 7'h00;
      cyc(240);
      rdc(REG_ATTACH, port_word(m));
      cyc(20);
      rdc(REG_ATTACH, 8'h00);
      rdc(REG_INT_STATUS, port_word(m));
      #1 see(hub_irq, 1'b1);
      wr(REG_INT_STATUS, 8'hFF);
      $display("attach round %0d done", r);
    end
    eop_test(s);
    $display("eop test done");
    plug <= m;
    cyc(320);
    up_dp <= 1'b0;
    cyc(1400);
    #1 see(bra, 1'b0);
    cyc(110);
    #1 see(bra, 1'b1);
    up_dp <= 1'b1;
    cyc(3);
    #1 see(bra, 1'b0);
    rdc(REG_ATTACH, 8'h00);
    rdc(REG_LOW_SPEED, 8'h00);
    rdc(REG_INT_STATUS, {1'b1, m});
    $display("bus reset test done");
    // A write while frozen must not land
    clk_en <= 1'b0;
    wr(REG_INT_MASK, 8'h00);
    clk_en <= 1'b1;
    rdc(REG_INT_MASK, 8'hFF);
    $display("clock enable test done");
    finish_test();
  end
endmodule
